// [bist_pkg.sv]
// constants and types for the serial link self-test checker
// How it works
// - self test runs while the enable pin or the enable config bit is set, the captured straps allow it and power down is low.
// - checking strobes come from the pixel clock or the internal oscillator, as selected.
// - an active test raises the back-channel test request toward the far transmitter.
// - once in test with lock, the result output goes high and checking begins.
// - each strobe that samples a symbol whose payload is not all zeros counts as one error.
// - every errored symbol drives the result low for half a pixel clock period, or one clk of the three-clk oscillator period.
// - at test end the result holds high if clean, constant low otherwise.
// - the held result stays until a new test, reset or power down.
// - the lock output stays valid throughout the whole test.
// - after the enable goes low the link returns to normal operation.
// - forward errors found after lock are counted in a readable status register.
// - the panel pattern runs while its enable bit is set and not powered down, even without video.
// - without a pixel clock the pattern runs from a programmed oscillator rate.
package bist_pkg;
  localparam int unsigned PAYLOAD_W = 35;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned PIX_W     = 24;
  // clock rates in mhz; oscillator strobe is derived from them
  localparam int unsigned CLK_MHZ   = 100;
  localparam int unsigned OSC_MHZ   = 33;
  localparam int unsigned OSC_DIV   = CLK_MHZ / OSC_MHZ;
  localparam logic [1:0]  OSC_LAST  = 2'(OSC_DIV - 1);
  localparam logic [1:0]  OSC_HALF  = 2'(OSC_DIV / 2);
  // pixel clock counted absent after this many cycles without a rising edge
  localparam logic [4:0]  PCLK_LOSS_CYC = 5'h10;
  // strap capture waits for the pin synchronisers to fill
  localparam logic [1:0]  STRAP_WAIT    = 2'h3;
  localparam logic [2:0]  STRAP_UPPER_OK = 3'h0;
  // register offsets
  localparam logic [ADDR_W-1:0] REG_BIST_CFG    = 8'h24;
  localparam logic [ADDR_W-1:0] REG_ERR_STATUS  = 8'h25;
  localparam logic [ADDR_W-1:0] REG_PATTERN_CFG = 8'h26;
  localparam logic [ADDR_W-1:0] REG_PATTERN_DIV = 8'h27;
  // field positions
  localparam int unsigned CFG_EN_BIT   = 0;
  localparam int unsigned CFG_OSC_BIT  = 1;
  localparam int unsigned CFG_ST_LSB   = 4;
  localparam int unsigned CFG_RES_BIT  = 6;
  localparam int unsigned PAT_EN_BIT   = 0;
  localparam logic [DATA_W-1:0] ERR_MAX     = 8'hff;
  localparam logic [DATA_W-1:0] PAT_DIV_RST = 8'h03;
  // synchroniser lanes
  localparam int unsigned SYNC_W    = 9;
  localparam int unsigned SY_PCLK   = 0;
  localparam int unsigned SY_LOCK   = 1;
  localparam int unsigned SY_EN     = 2;
  localparam int unsigned SY_CSEL   = 3;
  localparam int unsigned SY_PDN    = 4;
  localparam int unsigned SY_STRAP0 = 5;
  localparam int unsigned SY_STRAP1 = 6;
  // pattern bars
  localparam int unsigned BAR_MSB   = 7;
  localparam int unsigned BAR_LSB   = 5;
  localparam logic [7:0]  COLOR_ON  = 8'hff;
  localparam logic [7:0]  COLOR_OFF = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_WAIT_LOCK = 2'b01,
    ST_CHECK     = 2'b10
  } bist_state_e;
endpackage : bist_pkg

// [link_tx_model.sv]
// behavioural far-end transmitter for the self-test link
`timescale 1ns/100ps
module link_tx_model (
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic                           bc_req,
  input  wire logic                           inject,
  input  wire logic                           pclk_stop,
  input  wire logic                           lock_drop,
  input  wire logic                           crc_bad,
  output logic                                pclk,
  output logic                                lock,
  output logic      [bist_pkg::PAYLOAD_W-1:0] payload,
  output logic      [7:0]                     crc_err_q
);
  logic       req_q;
  logic [3:0] wake_q;

  // free pixel clock with its own phase; parks low when stopped
  initial
  begin
    pclk = 1'b0;
    #3;
    forever
    begin
      #40;
      pclk = pclk_stop ? 1'b0 : ~pclk;
    end
  end

  // wake on request and lock
  // once awake the far end stays on, so lock survives the end of a run
  always_ff @(posedge clk)
  begin
    if (reset)
      wake_q <= 4'h0;
    else if (bc_req && wake_q != 4'hf)
      wake_q <= wake_q + 4'h1;
  end
  assign lock = (wake_q == 4'hf) && !lock_drop;

  // all-zero symbols
  // a commanded symbol carries random nonzero bits, launched after the edge
  always @(posedge pclk)
  begin
    #1;
    payload = inject ? (35'($urandom) | 35'h1) : '0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      req_q <= 1'b0;
    else
      req_q <= bc_req;
    if (reset)
      crc_err_q <= 8'h00;
    else if (bc_req && !req_q)
      crc_err_q <= 8'h00;
    else if (bc_req && lock && crc_bad && crc_err_q != 8'hff)
      crc_err_q <= crc_err_q + 8'h01;
  end
endmodule : link_tx_model

// [panel_pattern_gen.sv]
// repetitive colour-bar panel pattern generator
`timescale 1ns/100ps
module panel_pattern_gen (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        run,
  input  wire logic                        pclk_tick,
  input  wire logic                        pclk_present,
  input  wire logic [bist_pkg::DATA_W-1:0] div,
  output logic      [bist_pkg::PIX_W-1:0]  pixel,
  output logic                             valid
);
  logic [bist_pkg::DATA_W-1:0] div_cnt_q;
  logic [7:0]                  pos_q;
  logic                        prog_tick;
  logic                        tick;
  logic [2:0]                  bar;

  assign prog_tick = (div_cnt_q >= div);
  assign tick      = pclk_present ? pclk_tick : prog_tick;
  assign bar       = pos_q[bist_pkg::BAR_MSB:bist_pkg::BAR_LSB];

  // programmable divider free-runs so the pattern needs no video input
  always_ff @(posedge clk)
  begin
    if (reset || prog_tick)
      div_cnt_q <= '0;
    else
      div_cnt_q <= div_cnt_q + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pos_q <= '0;
      pixel <= '0;
      valid <= 1'b0;
    end
    else
    begin
      valid <= run && tick;
      if (run && tick)
      begin
        pos_q <= pos_q + 8'h01;  // wraps, so the bars repeat
        pixel <= {bar[2] ? bist_pkg::COLOR_ON : bist_pkg::COLOR_OFF,
                  bar[1] ? bist_pkg::COLOR_ON : bist_pkg::COLOR_OFF,
                  bar[0] ? bist_pkg::COLOR_ON : bist_pkg::COLOR_OFF};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pattern_runs: assert property (run && tick |=> valid ##1 (pos_q == $past(pos_q, 2) + 8'h01 || ($past(run) && $past(tick))))
    else $error("pattern stalled while running");
  a_prog_tick_rate: assert property (!pclk_present && run && prog_tick |=> !prog_tick || div == '0)
    else $error("programmed oscillator strobe too fast");
endmodule : panel_pattern_gen

// [serial_link_bist_checker.sv]
// receiver self-test checker, result pin, error status and panel pattern
`timescale 1ns/100ps
module serial_link_bist_checker (
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic                           selftest_enable_pin,
  input  wire logic                           selftest_clock_select_pin,
  input  wire logic                           pclk_in,
  input  wire logic                           lock_in,
  input  wire logic                           power_down,
  input  wire logic                           strap_gpio_low_bit,
  input  wire logic [2:0]                     strap_gpio_upper,
  input  wire logic [bist_pkg::PAYLOAD_W-1:0] sym_payload,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  input  wire logic [bist_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [bist_pkg::DATA_W-1:0]    reg_wdata,
  output logic      [bist_pkg::DATA_W-1:0]    reg_rdata,
  output logic                                pass_out,
  output logic                                lock_out,
  output logic                                bc_selftest_req,
  output logic                                link_normal,
  output logic      [bist_pkg::PIX_W-1:0]     pattern_pixel,
  output logic                                pattern_valid
);
  logic [bist_pkg::SYNC_W-1:0]   raw;
  logic [bist_pkg::SYNC_W-1:0]   s1_q;
  logic [bist_pkg::SYNC_W-1:0]   s2_q;
  logic [bist_pkg::SYNC_W-1:0]   s3_q;
  logic [bist_pkg::SYNC_W-1:0]   filt_q;
  logic [bist_pkg::SYNC_W-1:0]   filt_d;
  logic                          pclk_rise;
  logic                          pclk_fall;
  logic                          lock_f;
  logic                          pdn_f;
  logic [4:0]                    gap_q;
  logic                          pclk_present;
  logic [1:0]                    osc_cnt_q;
  logic                          sel_osc;
  logic                          rise_tick;
  logic                          fall_tick;
  logic [1:0]                    strap_cnt_q;
  logic                          strap_taken_q;
  logic                          strap_ok_q;
  logic                          cfg_en_q;
  logic                          cfg_osc_q;
  logic                          pat_en_q;
  logic [bist_pkg::DATA_W-1:0]   pat_div_q;
  logic                          req;
  bist_pkg::bist_state_e         st_q;
  logic                          start;
  logic                          stop;
  logic                          enter_check;
  logic                          sym_err;
  logic                          err_seen_q;
  logic [bist_pkg::DATA_W-1:0]   err_cnt_q;

  // pin synchronisers: three flops, a change counts once stages two and three agree
  assign raw = {strap_gpio_upper, strap_gpio_low_bit, power_down, selftest_clock_select_pin,
                selftest_enable_pin, lock_in, pclk_in};
  genvar gi;
  generate
    for (gi = 0; gi < bist_pkg::SYNC_W; gi++)
    begin : g_sync
      assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          s1_q[gi]   <= 1'b0;
          s2_q[gi]   <= 1'b0;
          s3_q[gi]   <= 1'b0;
          filt_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi]   <= raw[gi];
          s2_q[gi]   <= s1_q[gi];
          s3_q[gi]   <= s2_q[gi];
          filt_q[gi] <= filt_d[gi];
        end
      end
    end
  endgenerate

  assign pclk_rise = filt_d[bist_pkg::SY_PCLK] && !filt_q[bist_pkg::SY_PCLK];
  assign pclk_fall = !filt_d[bist_pkg::SY_PCLK] && filt_q[bist_pkg::SY_PCLK];
  assign lock_f    = filt_q[bist_pkg::SY_LOCK];
  assign pdn_f     = filt_q[bist_pkg::SY_PDN];

  // pixel clock presence watchdog; saturates so it never wraps back to present
  always_ff @(posedge clk)
  begin
    if (reset)
      gap_q <= bist_pkg::PCLK_LOSS_CYC;
    else if (pclk_rise)
      gap_q <= '0;
    else if (gap_q != bist_pkg::PCLK_LOSS_CYC)
      gap_q <= gap_q + 5'h01;
  end
  assign pclk_present = (gap_q != bist_pkg::PCLK_LOSS_CYC);

  // internal oscillator strobes divided from clk
  always_ff @(posedge clk)
  begin
    if (reset || osc_cnt_q == bist_pkg::OSC_LAST)
      osc_cnt_q <= '0;
    else
      osc_cnt_q <= osc_cnt_q + 2'h1;
  end

  assign sel_osc   = filt_q[bist_pkg::SY_CSEL] || cfg_osc_q;
  assign rise_tick = sel_osc ? (osc_cnt_q == '0) : pclk_rise;
  assign fall_tick = sel_osc ? (osc_cnt_q == bist_pkg::OSC_HALF) : pclk_fall;

  // straps caught once synchronisers have filled after reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_cnt_q   <= '0;
      strap_taken_q <= 1'b0;
      strap_ok_q    <= 1'b0;
    end
    else if (!strap_taken_q)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == bist_pkg::STRAP_WAIT)
      begin
        strap_taken_q <= 1'b1;
        // agreed value taken before its flop, which would still hold the reset zero at this edge
        strap_ok_q    <= filt_d[bist_pkg::SY_STRAP0] &&
                         (filt_d[bist_pkg::SYNC_W-1:bist_pkg::SY_STRAP1] == bist_pkg::STRAP_UPPER_OK);
      end
    end
  end

  // configuration writes
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_en_q  <= 1'b0;
      cfg_osc_q <= 1'b0;
      pat_en_q  <= 1'b0;
      pat_div_q <= bist_pkg::PAT_DIV_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == bist_pkg::REG_BIST_CFG)
      begin
        cfg_en_q  <= reg_wdata[bist_pkg::CFG_EN_BIT];
        cfg_osc_q <= reg_wdata[bist_pkg::CFG_OSC_BIT];
      end
      else if (reg_addr == bist_pkg::REG_PATTERN_CFG)
        pat_en_q <= reg_wdata[bist_pkg::PAT_EN_BIT];
      else if (reg_addr == bist_pkg::REG_PATTERN_DIV)
        pat_div_q <= reg_wdata;
    end
  end

  // test request from pin or bit once straps allow it; the test lasts while either one is set and power down is low
  assign req         = strap_ok_q && !pdn_f && (filt_q[bist_pkg::SY_EN] || cfg_en_q);
  assign start       = (st_q == bist_pkg::ST_IDLE) && req;
  assign stop        = (st_q != bist_pkg::ST_IDLE) && !req;
  assign enter_check = (st_q == bist_pkg::ST_WAIT_LOCK) && req && lock_f;
  assign sym_err     = (st_q == bist_pkg::ST_CHECK) && lock_f && rise_tick && (sym_payload != '0);

  // test sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
      st_q <= bist_pkg::ST_IDLE;
    else
    begin
      case (st_q)
        bist_pkg::ST_IDLE:
          if (req)
            st_q <= bist_pkg::ST_WAIT_LOCK;
        bist_pkg::ST_WAIT_LOCK:
          if (!req)
            st_q <= bist_pkg::ST_IDLE;
          else if (lock_f)
            st_q <= bist_pkg::ST_CHECK;
        bist_pkg::ST_CHECK:
          if (!req)
            st_q <= bist_pkg::ST_IDLE;
        default:
          st_q <= bist_pkg::ST_IDLE;
      endcase
    end
  end

  // error count, saturating, cleared when a run starts
  always_ff @(posedge clk)
  begin
    if (reset || start)
    begin
      err_cnt_q  <= '0;
      err_seen_q <= 1'b0;
    end
    else if (sym_err)
    begin
      err_seen_q <= 1'b1;
      if (err_cnt_q != bist_pkg::ERR_MAX)
        err_cnt_q <= err_cnt_q + 8'h01;
    end
  end

  // result pin: live pulses during the run, held verdict afterwards
  always_ff @(posedge clk)
  begin
    if (reset || pdn_f)
      pass_out <= 1'b1;
    else if (start)
      pass_out <= 1'b0;  // nothing known until lock
    else if (enter_check)
      pass_out <= 1'b1;
    else if (stop)
      pass_out <= !(err_seen_q || sym_err);
    else if (sym_err)
      pass_out <= 1'b0;
    else if (st_q == bist_pkg::ST_CHECK && fall_tick)
      pass_out <= 1'b1;
  end

  // back-channel request; lock pass-through; normal mode
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bc_selftest_req <= 1'b0;
      lock_out        <= 1'b0;
      link_normal     <= 1'b1;
    end
    else
    begin
      bc_selftest_req <= req;
      lock_out        <= lock_f;
      link_normal     <= !req;
    end
  end

  // register read port; unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      if (reg_addr == bist_pkg::REG_ERR_STATUS)
        reg_rdata <= err_cnt_q;
      else if (reg_addr == bist_pkg::REG_BIST_CFG)
      begin
        reg_rdata <= '0;
        reg_rdata[bist_pkg::CFG_EN_BIT]                        <= cfg_en_q;
        reg_rdata[bist_pkg::CFG_OSC_BIT]                       <= cfg_osc_q;
        reg_rdata[bist_pkg::CFG_ST_LSB+1:bist_pkg::CFG_ST_LSB] <= st_q;
        reg_rdata[bist_pkg::CFG_RES_BIT]                       <= pass_out;
      end
      else if (reg_addr == bist_pkg::REG_PATTERN_CFG)
        reg_rdata <= {{(bist_pkg::DATA_W-1){1'b0}}, pat_en_q};
      else if (reg_addr == bist_pkg::REG_PATTERN_DIV)
        reg_rdata <= pat_div_q;
      else
        reg_rdata <= '0;
    end
  end

  // panel pattern, independent of the link
  panel_pattern_gen u_pattern (
    .clk          (clk),
    .reset        (reset),
    .run          (pat_en_q && !pdn_f),
    .pclk_tick    (pclk_rise),
    .pclk_present (pclk_present),
    .div          (pat_div_q),
    .pixel        (pattern_pixel),
    .valid        (pattern_valid)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_enter_mode: assert property (st_q == bist_pkg::ST_IDLE && strap_ok_q && !pdn_f && cfg_en_q
                                 |=> st_q == bist_pkg::ST_WAIT_LOCK)
    else $error("config enable did not start a test");
  a_request_sent: assert property (start |=> bc_selftest_req && !link_normal)
    else $error("back-channel request missing at start");
  a_lock_pass_high: assert property (enter_check |=> pass_out && st_q == bist_pkg::ST_CHECK)
    else $error("result not high on lock");
  a_error_counted: assert property (sym_err && !pdn_f && err_cnt_q != bist_pkg::ERR_MAX
                                    |=> !pass_out && err_cnt_q == $past(err_cnt_q) + 8'h01)
    else $error("errored symbol not counted");
  a_pulse_returns: assert property ($fell(pass_out) && st_q == bist_pkg::ST_CHECK && req
                                    |-> ##[1:12] (pass_out || st_q != bist_pkg::ST_CHECK))
    else $error("error pulse did not return high");
  a_final_fail: assert property (stop && err_seen_q && !pdn_f |=> !pass_out)
    else $error("failed run did not hold low");
  a_result_held: assert property (st_q == bist_pkg::ST_IDLE && !req && !pdn_f |=> $stable(pass_out))
    else $error("held result changed");
  a_lock_valid: assert property (st_q != bist_pkg::ST_IDLE |-> ##1 lock_out == $past(lock_f))
    else $error("lock output not tracking");
  a_ignore_unlocked: assert property (st_q == bist_pkg::ST_CHECK && !lock_f && !start
                                      |=> err_cnt_q == $past(err_cnt_q))
    else $error("error counted without lock");

  c_clean_run: cover property (enter_check ##[1:200] stop && !err_seen_q);
  c_error_pulse: cover property (sym_err ##[1:12] pass_out);
  c_failed_run: cover property (stop && err_seen_q);
  c_osc_check: cover property (sel_osc && sym_err);
endmodule : serial_link_bist_checker

// [serial_link_bist_checker_tb.sv]
// self-checking bench for the serial link self-test checker
`timescale 1ns/100ps
module serial_link_bist_checker_tb;
  logic                           clk, reset, en_pin, csel_pin, power_down;
  logic                           strap_lo, reg_wr, reg_rd, rd_seen, pass_q;
  logic [2:0]                     strap_up;
  logic [7:0]                     reg_addr, reg_wdata, reg_rdata, crc_cnt, div;
  logic                           pass_out, lock_out, bc_req, link_normal;
  logic                           pattern_valid, pclk, lock, inject;
  logic                           pclk_stop, lock_drop, crc_bad;
  logic [23:0]                    pattern_pixel;
  logic [bist_pkg::PAYLOAD_W-1:0] payload;
  int                             errors, comparisons, pulses, ticks, pix_n;
  logic [7:0]                     exp_q[$];

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  serial_link_bist_checker dut (
    .clk(clk), .reset(reset), .selftest_enable_pin(en_pin),
    .selftest_clock_select_pin(csel_pin), .pclk_in(pclk), .lock_in(lock),
    .power_down(power_down), .strap_gpio_low_bit(strap_lo),
    .strap_gpio_upper(strap_up), .sym_payload(payload), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pass_out(pass_out), .lock_out(lock_out),
    .bc_selftest_req(bc_req), .link_normal(link_normal),
    .pattern_pixel(pattern_pixel), .pattern_valid(pattern_valid)
  );

  link_tx_model far_end (
    .clk(clk), .reset(reset), .bc_req(bc_req), .inject(inject),
    .pclk_stop(pclk_stop), .lock_drop(lock_drop), .crc_bad(crc_bad),
    .pclk(pclk), .lock(lock), .payload(payload), .crc_err_q(crc_cnt)
  );

  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // settle past the edge so reads never race the design's updates
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // the expected answer is noted first; the monitor takes it off later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd

  function automatic logic pick(input int s);
    return (s == 0) ? bc_req : (s == 1) ? lock_out : pass_out;
  endfunction : pick

  task automatic wait_for(input int s, input logic v);
    int n = 0;
    while (pick(s) !== v)
    begin
      cyc(1);
      n++;
      if (n > 400)
      begin
        errors++;
        $display("MISMATCH wait %0d expected %b seen timeout", s, v);
        end_sim();
      end
    end
  endtask : wait_for

  // one bad symbol, then quiet symbols so the pulse can finish
  task automatic inj;
    @(posedge pclk);
    inject <= 1'b1;
    @(posedge pclk);
    inject <= 1'b0;
    repeat (3) @(posedge pclk);
    cyc(1);
  endtask : inj

  task automatic do_reset;
    reset <= 1'b1;
    cyc(6);
    reset <= 1'b0;
    cyc(8);
  endtask : do_reset

  // read answers against notes; count low pulses and pattern ticks
  always @(posedge clk)
  begin
    if (rd_seen)
      chk("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
    pass_q <= pass_out;
    if (pass_q && !pass_out)
      pulses++;
    if (pattern_valid)
    begin
      ticks++;
      chk("pixel_hi", pattern_pixel[23:16], pix_n[7] ? 8'hff : 8'h00);
      chk("pixel_mid", pattern_pixel[15:8], pix_n[6] ? 8'hff : 8'h00);
      chk("pixel_lo", pattern_pixel[7:0], pix_n[5] ? 8'hff : 8'h00);
      pix_n++;
    end
  end

  initial
  begin
    {reset, strap_lo} = 2'b11;
    {en_pin, csel_pin, power_down, reg_wr, reg_rd} = '0;
    {inject, pclk_stop, lock_drop, crc_bad} = '0;
    {strap_up, reg_addr, reg_wdata} = '0;
    void'($urandom(32'he91c));
    do_reset();
    chk("pass_out", 8'(pass_out), 8'h01);
    chk("link_normal", 8'(link_normal), 8'h01);
    rd(8'h24, 8'h40);
    wr(8'h25, 8'($urandom));
    rd(8'h25, 8'h00);
    wr(8'h3c, 8'($urandom));
    rd(8'h3c, 8'h00);
    $display("test reset done");
    @(posedge clk) en_pin <= 1'b1;
    wait_for(0, 1'b1);
    chk("link_normal", 8'(link_normal), 8'h00);
    wait_for(1, 1'b1);
    wait_for(2, 1'b1);
    rd(8'h24, 8'h60);
    pulses = 0;
    @(posedge clk) crc_bad <= 1'b1;
    cyc(2);
    crc_bad <= 1'b0;
    cyc(100);
    chk("lock_out", 8'(lock_out), 8'h01);
    chk("pulses", 8'(pulses), 8'h00);
    @(posedge clk) en_pin <= 1'b0;
    wait_for(0, 1'b0);
    chk("pass_out", 8'(pass_out), 8'h01);
    chk("link_normal", 8'(link_normal), 8'h01);
    chk("crc_cnt", crc_cnt, 8'h02);
    $display("test clean run done");
    wr(8'h24, 8'h01);
    wait_for(0, 1'b1);
    wait_for(2, 1'b1);
    chk("crc_cnt", crc_cnt, 8'h00);
    pulses = 0;
    repeat (3) inj();
    chk("pulses", 8'(pulses), 8'h03);
    rd(8'h25, 8'h03);
    wr(8'h24, 8'h00);
    wait_for(0, 1'b0);
    chk("pass_out", 8'(pass_out), 8'h00);
    cyc(50);
    chk("pass_out", 8'(pass_out), 8'h00);
    $display("test errored run done");
    @(posedge clk) {csel_pin, en_pin} <= 2'b11;
    wait_for(0, 1'b1);
    wait_for(2, 1'b1);
    rd(8'h25, 8'h00);
    pulses = 0;
    lock_drop <= 1'b1;
    cyc(10);
    inj();
    lock_drop <= 1'b0;
    cyc(20);
    chk("pulses", 8'(pulses), 8'h00);
    rd(8'h25, 8'h00);
    inj();
    chk("osc pulses", 8'(pulses >= 2), 8'h01);
    @(posedge clk) {csel_pin, en_pin} <= 2'b00;
    wait_for(0, 1'b0);
    chk("pass_out", 8'(pass_out), 8'h00);
    $display("test oscillator run done");
    @(posedge clk) power_down <= 1'b1;
    cyc(6);
    chk("pass_out", 8'(pass_out), 8'h01);
    power_down <= 1'b0;
    strap_up <= 3'h2;
    do_reset();
    @(posedge clk) en_pin <= 1'b1;
    cyc(20);
    chk("bc_req", 8'(bc_req), 8'h00);
    en_pin <= 1'b0;
    strap_up <= 3'h0;
    do_reset();
    $display("test power down and straps done");
    div = 8'h02 + 8'($urandom % 4);
    wr(8'h27, div);
    wr(8'h26, 8'h01);
    cyc(20);
    ticks = 0;
    cyc(160);
    chk("ticks", 8'(ticks), 8'd20);
    pclk_stop <= 1'b1;
    cyc(40);
    ticks = 0;
    cyc(120);
    chk("ticks", 8'(ticks), 8'(120 / (int'(div) + 1)));
    power_down <= 1'b1;
    cyc(10);
    ticks = 0;
    cyc(60);
    chk("ticks", 8'(ticks), 8'h00);
    $display("test pattern done");
    end_sim();
  end
endmodule : serial_link_bist_checker_tb
